//--- dtdma_consts.vh
// Purpose: Constants of the display DMA transfer controller
// Assumes: 8-bit register port, byte offsets as printed
// Notes: Included by both design files
//
// Summary of operation
// (RQ1) 24-bit source address in three bytes
// (RQ2) Config bit 1: 0 continuous, 1 block
// (RQ3) Continuous count is 19 bits over three bytes
// (RQ4) Block width is 10 bits, upper in own register
// (RQ5) Block height is 10 bits, upper in own register
// (RQ6) Picture width 10 bits, low three block only
// (RQ7) Start bit written 1 clears itself
// (RQ8) Config bit 0 reads busy state
// (RQ9) Block copies rows, stepping by picture width
// (RQ10) Host sets parameters first, keeps them while busy
`ifndef DTDMA_CONSTS_VH
`define DTDMA_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DTDMA_OFS_SRC0 8'hb0
`define DTDMA_OFS_SRC1 8'hb1
`define DTDMA_OFS_SRC2 8'hb2
`define DTDMA_OFS_WID0 8'hb4
`define DTDMA_OFS_WID1 8'hb5
`define DTDMA_OFS_HGT0 8'hb6
`define DTDMA_OFS_HGT1 8'hb7
`define DTDMA_OFS_PIC0 8'hb8
`define DTDMA_OFS_PIC1 8'hb9
`define DTDMA_OFS_IRQ_STAT 8'hba
`define DTDMA_OFS_IRQ_MASK 8'hbb
`define DTDMA_OFS_CFG 8'hbf

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define DTDMA_CFG_START_BIT 0
`define DTDMA_CFG_MODE_BIT 1
`define DTDMA_UPPER_MSB 1
`define DTDMA_PIC_SPLIT 3
`define DTDMA_IRQ_DONE_BIT 0
`define DTDMA_IRQ_REFUSE_BIT 1
`define DTDMA_IRQ_BITS 2
`define DTDMA_RST_BYTE 8'h00
`define DTDMA_RST_UPPER 2'h0
`define DTDMA_RST_IRQ 2'h0
`define DTDMA_RST_ADDR 24'h000000
`define DTDMA_RST_COL 19'h00000
`define DTDMA_RST_ROW 10'h000
`define DTDMA_ONE_COL 19'h00001
`define DTDMA_ONE_ROW 10'h001
`define DTDMA_ONE_ADDR 24'h000001
`define DTDMA_STRIDE_PAD 14'h0000
`define DTDMA_RUN_PAD 9'h000
`define DTDMA_BYTE_MSB 7
`define DTDMA_PIC_LOW_ZERO 3'h0
`define DTDMA_HI_ZERO 6'h00
`define DTDMA_CFG_ZERO 6'h00

`endif

//--- dtdma_addr_gen.v
// Purpose: Source address walker over runs and rows
// Assumes: Load and step never in the same cycle
// Notes: Continuous mode is one row of the full count
`timescale 1ns/100ps
`include "dtdma_consts.vh"

module dtdma_addr_gen (
    input wire ref_clk,
    input wire rst,
    input wire load,
    input wire step,
    input wire [23:0] base_addr,
    input wire [18:0] run_len,
    input wire [9:0] rows,
    input wire [9:0] stride,
    output wire [23:0] addr,
    output wire last_unit,
    output wire empty
);

reg [18:0] col_r;
reg [18:0] len_r;
reg [9:0] row_r;
reg [23:0] base_r;
reg [23:0] addr_r;
wire [23:0] next_base;

assign next_base = base_r + {`DTDMA_STRIDE_PAD, stride};
assign addr = addr_r;
assign last_unit = (col_r == `DTDMA_ONE_COL) && (row_r == `DTDMA_ONE_ROW);
assign empty = (col_r == `DTDMA_RST_COL) || (row_r == `DTDMA_RST_ROW);

// ----------------------------------------------------------------
// Column and row counting
// ----------------------------------------------------------------
always @(posedge ref_clk)
begin
    if (rst)
    begin
        col_r <= `DTDMA_RST_COL;
        len_r <= `DTDMA_RST_COL;
        row_r <= `DTDMA_RST_ROW;
        base_r <= `DTDMA_RST_ADDR;
        addr_r <= `DTDMA_RST_ADDR;
    end
    else if (load)
    begin
        col_r <= run_len;
        len_r <= run_len;
        row_r <= rows;
        base_r <= base_addr;
        addr_r <= base_addr;
    end
    else if (step)
    begin
        if (col_r > `DTDMA_ONE_COL)
        begin
            col_r <= col_r - `DTDMA_ONE_COL;
            addr_r <= addr_r + `DTDMA_ONE_ADDR;
        end
        else
        begin
            // Next row starts one picture width further on
            col_r <= len_r; // RQ9
            row_r <= row_r - `DTDMA_ONE_ROW; // RQ9
            base_r <= next_base; // RQ9
            addr_r <= next_base; // RQ9
        end
    end
end

endmodule

//--- dtdma_ctrl.v
// Purpose: Register-programmed DMA unit of a display controller
// Assumes: Memory port answers on the same clock
// Notes: One byte fetched per unit, streamed out one cycle later
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
`include "dtdma_consts.vh"

module dtdma_ctrl (
    input wire ref_clk,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    output wire irq,
    output wire mem_req,
    output wire [23:0] mem_addr,
    input wire mem_ack,
    input wire [7:0] mem_rdata,
    output reg [7:0] pix_data,
    output reg pix_valid,
    output wire busy
);

// ----------------------------------------------------------------
// States
// ----------------------------------------------------------------
localparam [3:0] ST_IDLE = 4'h1;
localparam [3:0] ST_CHECK = 4'h2;
localparam [3:0] ST_FETCH = 4'h4;
localparam [3:0] ST_FINISH = 4'h8;

reg [3:0] state_r;
reg [3:0] state_nxt;
reg [7:0] src_lo_r;
reg [7:0] src_mid_r;
reg [7:0] src_hi_r;
reg [7:0] wid_lo_r;
reg [1:0] wid_up_r;
reg [7:0] hgt_lo_r;
reg [1:0] hgt_up_r;
reg [7:0] pic_lo_r;
reg [1:0] pic_up_r;
reg mode_r;
reg start_r;
reg [1:0] irq_stat_r;
reg [1:0] irq_mask_r;
reg [1:0] irq_stat_nxt;
reg [7:0] rdata_nxt;

wire wr_cfg;
wire cfg_start;
wire gen_load;
wire gen_step;
wire gen_last;
wire gen_empty;
wire [23:0] src_addr;
wire [18:0] xfer_count;
wire [9:0] blk_width;
wire [9:0] blk_height;
wire [9:0] pic_width;
wire [18:0] run_len;
wire [9:0] rows;
wire [1:0] irq_event;

// Register select shared by write and read paths
function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
        hit = (addr == ofs);
    end
endfunction

// ----------------------------------------------------------------
// Parameter assembly
// ----------------------------------------------------------------
assign src_addr = {src_hi_r, src_mid_r, src_lo_r}; // RQ1
assign xfer_count = {pic_lo_r[`DTDMA_PIC_SPLIT-1:0], hgt_lo_r,
                     wid_lo_r}; // RQ3
assign blk_width = {wid_up_r, wid_lo_r}; // RQ4
assign blk_height = {hgt_up_r, hgt_lo_r}; // RQ5
// Low three bits belong to the count in continuous mode
assign pic_width = {pic_up_r, pic_lo_r[`DTDMA_BYTE_MSB:`DTDMA_PIC_SPLIT],
                    mode_r ? pic_lo_r[`DTDMA_PIC_SPLIT-1:0]
                           : `DTDMA_PIC_LOW_ZERO}; // RQ6
assign run_len = mode_r ? {`DTDMA_RUN_PAD, blk_width} : xfer_count; // RQ2
assign rows = mode_r ? blk_height : `DTDMA_ONE_ROW; // RQ2

// ----------------------------------------------------------------
// Register writes
// ----------------------------------------------------------------
assign wr_cfg = reg_wr && hit(reg_addr, `DTDMA_OFS_CFG);
assign cfg_start = wr_cfg && reg_wdata[`DTDMA_CFG_START_BIT];

always @(posedge ref_clk)
begin
    if (rst)
    begin
        src_lo_r <= `DTDMA_RST_BYTE;
        src_mid_r <= `DTDMA_RST_BYTE;
        src_hi_r <= `DTDMA_RST_BYTE;
        wid_lo_r <= `DTDMA_RST_BYTE;
        wid_up_r <= `DTDMA_RST_UPPER;
        hgt_lo_r <= `DTDMA_RST_BYTE;
        hgt_up_r <= `DTDMA_RST_UPPER;
        pic_lo_r <= `DTDMA_RST_BYTE;
        pic_up_r <= `DTDMA_RST_UPPER;
        mode_r <= 1'b0;
        irq_mask_r <= `DTDMA_RST_IRQ;
    end
    else if (reg_wr)
    begin
        if (hit(reg_addr, `DTDMA_OFS_SRC0))
            src_lo_r <= reg_wdata; // RQ1
        if (hit(reg_addr, `DTDMA_OFS_SRC1))
            src_mid_r <= reg_wdata; // RQ1
        if (hit(reg_addr, `DTDMA_OFS_SRC2))
            src_hi_r <= reg_wdata; // RQ1
        if (hit(reg_addr, `DTDMA_OFS_WID0))
            wid_lo_r <= reg_wdata; // RQ3
        if (hit(reg_addr, `DTDMA_OFS_WID1))
            wid_up_r <= reg_wdata[`DTDMA_UPPER_MSB:0]; // RQ4
        if (hit(reg_addr, `DTDMA_OFS_HGT0))
            hgt_lo_r <= reg_wdata; // RQ3
        if (hit(reg_addr, `DTDMA_OFS_HGT1))
            hgt_up_r <= reg_wdata[`DTDMA_UPPER_MSB:0]; // RQ5
        if (hit(reg_addr, `DTDMA_OFS_PIC0))
            pic_lo_r <= reg_wdata; // RQ6
        if (hit(reg_addr, `DTDMA_OFS_PIC1))
            pic_up_r <= reg_wdata[`DTDMA_UPPER_MSB:0]; // RQ6
        if (hit(reg_addr, `DTDMA_OFS_IRQ_MASK))
            irq_mask_r <= reg_wdata[`DTDMA_IRQ_BITS-1:0];
        // Mode is frozen while a transfer runs
        if (wr_cfg && !busy)
            mode_r <= reg_wdata[`DTDMA_CFG_MODE_BIT]; // RQ2 RQ10
    end
end

// ----------------------------------------------------------------
// Start bit, taken by the engine in the next cycle
// ----------------------------------------------------------------
always @(posedge ref_clk)
begin
    if (rst)
        start_r <= 1'b0;
    else if (cfg_start && !busy)
        start_r <= 1'b1;
    else
        start_r <= 1'b0; // RQ7
end

// ----------------------------------------------------------------
// Engine
// ----------------------------------------------------------------
assign busy = !state_r[0] || start_r; // RQ8
assign mem_req = state_r == ST_FETCH;
assign gen_load = start_r;
assign gen_step = mem_req && mem_ack;

always @*
begin
    state_nxt = state_r;
    case (state_r)
        ST_IDLE:
        begin
            if (start_r)
                state_nxt = ST_CHECK;
        end
        ST_CHECK:
        begin
            // Zero length run or zero rows ends at once
            if (gen_empty)
                state_nxt = ST_FINISH;
            else
                state_nxt = ST_FETCH;
        end
        ST_FETCH:
        begin
            if (gen_step && gen_last)
                state_nxt = ST_FINISH; // RQ9
        end
        ST_FINISH:
        begin
            state_nxt = ST_IDLE;
        end
        default:
        begin
            state_nxt = ST_IDLE;
        end
    endcase
end

always @(posedge ref_clk)
begin
    if (rst)
        state_r <= ST_IDLE;
    else
        state_r <= state_nxt;
end

dtdma_addr_gen u_addr_gen (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(gen_load),
    .step(gen_step),
    .base_addr(src_addr),
    .run_len(run_len),
    .rows(rows),
    .stride(pic_width),
    .addr(mem_addr),
    .last_unit(gen_last),
    .empty(gen_empty)
);

// ----------------------------------------------------------------
// Output stream
// ----------------------------------------------------------------
always @(posedge ref_clk)
begin
    if (rst)
    begin
        pix_data <= `DTDMA_RST_BYTE;
        pix_valid <= 1'b0;
    end
    else
    begin
        pix_valid <= gen_step;
        if (gen_step)
            pix_data <= mem_rdata;
    end
end

// ----------------------------------------------------------------
// Interrupt status, set wins over clear by read
// ----------------------------------------------------------------
assign irq_event[`DTDMA_IRQ_DONE_BIT] = state_r == ST_FINISH;
assign irq_event[`DTDMA_IRQ_REFUSE_BIT] = cfg_start && busy;
assign irq = |(irq_stat_r & irq_mask_r);

always @*
begin
    irq_stat_nxt = irq_stat_r;
    if (reg_rd && hit(reg_addr, `DTDMA_OFS_IRQ_STAT))
        irq_stat_nxt = `DTDMA_RST_IRQ;
    irq_stat_nxt = irq_stat_nxt | irq_event;
end

always @(posedge ref_clk)
begin
    if (rst)
        irq_stat_r <= `DTDMA_RST_IRQ;
    else
        irq_stat_r <= irq_stat_nxt;
end

// ----------------------------------------------------------------
// Register reads, data in the following cycle
// ----------------------------------------------------------------
always @*
begin
    rdata_nxt = `DTDMA_RST_BYTE;
    case (reg_addr)
        `DTDMA_OFS_SRC0:
            rdata_nxt = src_lo_r;
        `DTDMA_OFS_SRC1:
            rdata_nxt = src_mid_r;
        `DTDMA_OFS_SRC2:
            rdata_nxt = src_hi_r;
        `DTDMA_OFS_WID0:
            rdata_nxt = wid_lo_r;
        `DTDMA_OFS_WID1:
            rdata_nxt = {`DTDMA_HI_ZERO, wid_up_r};
        `DTDMA_OFS_HGT0:
            rdata_nxt = hgt_lo_r;
        `DTDMA_OFS_HGT1:
            rdata_nxt = {`DTDMA_HI_ZERO, hgt_up_r};
        `DTDMA_OFS_PIC0:
            rdata_nxt = pic_lo_r;
        `DTDMA_OFS_PIC1:
            rdata_nxt = {`DTDMA_HI_ZERO, pic_up_r};
        `DTDMA_OFS_IRQ_STAT:
            rdata_nxt = {`DTDMA_HI_ZERO, irq_stat_r};
        `DTDMA_OFS_IRQ_MASK:
            rdata_nxt = {`DTDMA_HI_ZERO, irq_mask_r};
        `DTDMA_OFS_CFG:
            rdata_nxt = {`DTDMA_CFG_ZERO, mode_r, busy}; // RQ8
        default:
            rdata_nxt = `DTDMA_RST_BYTE;
    endcase
end

always @(posedge ref_clk)
begin
    if (rst)
        reg_rdata <= `DTDMA_RST_BYTE;
    else if (reg_rd)
        reg_rdata <= rdata_nxt;
    else
        reg_rdata <= `DTDMA_RST_BYTE;
end

endmodule

//--- dtdma_mem_model.sv
// Purpose: Byte memory behind the fetch port
// Assumes: Data is a hash of the address
// Notes: Slow mode acks every other cycle
`timescale 1ns/100ps
module dtdma_mem_model (
    input wire ref_clk,
    input wire slow,
    input wire mem_req,
    input wire [23:0] mem_addr,
    output wire mem_ack,
    output wire [7:0] mem_rdata
);
    reg ph_r = 1'b0;
    wire [7:0] v = mem_addr[7:0] ^ mem_addr[15:8] ^ mem_addr[23:16];
    always @(posedge ref_clk)
        ph_r <= ~ph_r;
    assign mem_ack = mem_req & (~slow | ph_r);
    // Data not acked shows the inverse
    assign mem_rdata = mem_ack ? v : ~v;
endmodule

//--- dtdma_ctrl_chk.sv
// Purpose: Port checker of dtdma_ctrl
// Assumes: Strobes never overlap
// Notes: Bound to every dtdma_ctrl
`timescale 1ns/100ps
module dtdma_ctrl_chk (
    input wire ref_clk,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire irq,
    input wire mem_req,
    input wire [23:0] mem_addr,
    input wire mem_ack,
    input wire [7:0] mem_rdata,
    input wire [7:0] pix_data,
    input wire pix_valid,
    input wire busy
);
    reg start_r;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    always @(posedge ref_clk)
        start_r <= !rst && reg_wr && reg_addr == 8'hbf && reg_wdata[0];
    rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not idle");
    busy_read_a: assert property (reg_rd && reg_addr == 8'hbf
        |=> reg_rdata[0] == $past(busy)) else $error("busy read");
    start_busy_a: assert property (reg_wr && reg_addr == 8'hbf
        && reg_wdata[0] && !busy |=> busy) else $error("start ignored");
    busy_cause_a: assert property ($rose(busy) |-> start_r)
        else $error("busy without start");
    req_busy_a: assert property (mem_req |-> busy)
        else $error("fetch while idle");
    req_hold_a: assert property (mem_req && !mem_ack
        |=> mem_req && $stable(mem_addr)) else $error("fetch dropped");
    pix_data_a: assert property (mem_req && mem_ack
        |=> pix_valid && pix_data == $past(mem_rdata)) else $error("pix");
    pix_cause_a: assert property (pix_valid
        |-> $past(mem_req) && $past(mem_ack)) else $error("stray pix");
endmodule
bind dtdma_ctrl dtdma_ctrl_chk u_chk (.ref_clk(ref_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .pix_data(pix_data), .pix_valid(pix_valid), .busy(busy));

//--- dtdma_ctrl_tb.sv
// Purpose: Self-checking bench of dtdma_ctrl
// Assumes: Memory model answers fetches
// Notes: Each table row is one transfer
`timescale 1ns/100ps
module dtdma_ctrl_tb;
    typedef struct packed {
        logic md;
        logic [23:0] src;
        logic [9:0] w;
        logic [9:0] h;
        logic [9:0] pw;
        logic sl;
    } dtdma_row_t;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic slow = 1'b0;
    wire [7:0] reg_rdata, mem_rdata, pix_data;
    wire [23:0] mem_addr;
    wire irq, mem_req, mem_ack, pix_valid, busy;
    int error_cnt = 0;
    int num_checks = 0;
    int i;
    logic [7:0] d;
    logic [7:0] got[$];
    dtdma_row_t rows[5];
    logic [7:0] ra[13] = '{8'hb0, 8'hb1, 8'hb2, 8'hb4, 8'hb5, 8'hb6,
        8'hb7, 8'hb8, 8'hb9, 8'hbf, 8'hb3, 8'hba, 8'hbb};
    logic [7:0] rm[13] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h03, 8'hff,
        8'h03, 8'hff, 8'h03, 8'h02, 8'h00, 8'h00, 8'h03};
    always #25 ref_clk = ~ref_clk;
    dtdma_ctrl u_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .pix_data(pix_data), .pix_valid(pix_valid), .busy(busy));
    dtdma_mem_model u_mem (.ref_clk(ref_clk), .slow(slow),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));
    always @(posedge ref_clk)
        if (pix_valid === 1'b1)
            got.push_back(pix_data);
    function automatic logic [7:0] xf(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16];
    endfunction
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask
    task automatic go(input dtdma_row_t r, input bit refuse);
        logic [7:0] v;
        logic [9:0] pw;
        int n, k, j;
        got.delete();
        slow <= r.sl;
        wr(8'hb0, r.src[7:0]);
        wr(8'hb1, r.src[15:8]);
        wr(8'hb2, r.src[23:16]);
        wr(8'hb4, r.w[7:0]);
        wr(8'hb5, {6'h00, r.w[9:8]});
        wr(8'hb6, r.h[7:0]);
        wr(8'hb7, {6'h00, r.h[9:8]});
        wr(8'hb8, r.pw[7:0]);
        wr(8'hb9, {6'h00, r.pw[9:8]});
        wr(8'hbf, {6'h00, r.md, 1'b0});
        wr(8'hbf, {6'h00, r.md, 1'b1});
        rd(8'hbf, v);
        chk(v, {6'h00, r.md, 1'b1});
        // Start and mode flip while busy
        if (refuse)
            wr(8'hbf, 8'h03);
        for (k = 0; k < 3000 && busy !== 1'b0; k++)
        begin
            @(posedge ref_clk);
            #1;
        end
        chk(busy, 1'b0);
        rd(8'hbf, v);
        chk(v, {6'h00, r.md, 1'b0});
        pw = r.md ? r.pw : {r.pw[9:3], 3'h0};
        n = r.md ? r.w * r.h : {r.pw[2:0], r.h[7:0], r.w[7:0]};
        chk(got.size(), n);
        for (k = 0; k < n; k++)
        begin
            j = r.md ? k / r.w * pw + k % r.w : k;
            chk(got[k], xf(r.src + j));
        end
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        summarize;
    end
    initial
    begin
        rows[0] = {1'b0, 24'h1234fe, 10'h005, 10'h000, 10'h0f8, 1'b0};
        rows[1] = {1'b0, 24'h00fffe, 10'h002, 10'h001, 10'h000, 1'b1};
        rows[2] = {1'b1, 24'h000100, 10'h003, 10'h004, 10'h10a, 1'b0};
        rows[3] = {1'b1, 24'h7f0010, 10'h102, 10'h002, 10'h3ff, 1'b1};
        rows[4] = {1'b0, 24'h000000, 10'h000, 10'h000, 10'h000, 1'b0};
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        for (i = 0; i < 13; i++)
        begin
            rd(ra[i], d);
            chk(d, 8'h00);
            wr(ra[i], 8'h5a);
            rd(ra[i], d);
            chk(d, 8'h5a & rm[i]);
        end
        for (i = 0; i < 5; i++)
            go(rows[i], 1'b0);
        chk(irq, 1'b0);
        rd(8'hba, d);
        chk(d, 8'h01);
        wr(8'hbb, 8'h03);
        go(rows[0], 1'b1);
        chk(irq, 1'b1);
        rd(8'hba, d);
        chk(d, 8'h03);
        chk(irq, 1'b0);
        wr(8'hbb, 8'h02);
        go(rows[4], 1'b0);
        chk(irq, 1'b0);
        rd(8'hba, d);
        chk(d, 8'h01);
        // Reset in the middle of a run
        wr(8'hb4, 8'h05);
        wr(8'hbf, 8'h01);
        // Reset lands while fetches are under way
        repeat (3) @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk(busy, 1'b0);
        chk(mem_req, 1'b0);
        rd(8'hb4, d);
        chk(d, 8'h00);
        summarize;
    end
endmodule
